// ---- logic/dhtrc_core.sv ----
// Purpose: two 16-bit timer halves, 32-bit timer, 32-bit RTC
// Assumes: register strobes synchronous, one cycle long
// Notes:   edge count, edge time and pwm modes not built
//
// Functional notes
// - reset: idle, controls cleared, counters/loads ffff
// - reset: prescale counters and registers zero
// - config 0 wide, 1 rtc, 4 split
// - wide write of low load fills both
// - wide read of low count returns both
// - wide mode uses only low mode field
// - wide: enable counts down, reload after zero
// - one-shot stops and clears enable; periodic continues
// - zero sets raw timeout, masked if enabled
// - trigger enable gives pulse at zero
// - load write while running reloads next cycle
// - low stall freezes wide counter
// - rtc counts up, first load is one
// - 32.768 kHz pin divided to 1 Hz
// - rtc match rolls over to zero
// - rtc match sets raw, masked flags; clear
// - stall permit keeps rtc counting under stall
// - wide modes single timer, split independent
// - split halves: 16-bit down, 8-bit prescale
// - split zero reloads load and prescale
// - split zero sets half timeout flags, trigger
// - half stall freezes that half
// - prescale N gives N+1 clocks per count
`timescale 1ns/1ps
module dhtrc_core
  import dhtrc_pkg::*;
#(
  parameter int RTC_EDGES = dhtrc_pkg::RTC_DIV
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // pins and events
  input  wire logic        capture_pin_zero_i,
  output logic             trig_low_o,
  output logic             trig_high_o,
  output logic             irq_o
);
  // ==========================================
  // state
  logic [2:0]  cfg_ff;
  logic [1:0]  mda_ff, mdb_ff;
  logic        ena_ff, sta_ff, ota_ff, permit_ff, enb_ff, stb_ff, otb_ff;
  logic [2:0]  imr_ff, ris_ff;   // {b timeout, rtc match, a timeout}
  logic [15:0] ila_ff, ilb_ff, cna_ff, cnb_ff;
  logic [7:0]  pra_ff, prb_ff, psa_ff, psb_ff;
  logic [31:0] mat_ff;
  logic        rtc_seen_ff;
  logic [15:0] nxt_cna, nxt_cnb;
  logic [7:0]  nxt_psa, nxt_psb;
  logic        tick;
  dhtrc_gm_t   gm;

  // ==========================================
  // rtc pin divider
  dhtrc_rtc_div #(.DIV(RTC_EDGES)) u_div (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (capture_pin_zero_i),
    .tick_o    (tick)
  );

  // ==========================================
  // decode
  assign gm = dhtrc_gm(cfg_ff);
  wire wide   = (gm == GM_WIDE);
  wire rtc    = (gm == GM_RTC);
  wire split  = (gm == GM_SPLIT);
  wire w_cfg  = wr_i & (addr_i == A_CFG);
  wire w_mda  = wr_i & (addr_i == A_MDA);
  wire w_mdb  = wr_i & (addr_i == A_MDB);
  wire w_ctl  = wr_i & (addr_i == A_CTL);
  wire w_imr  = wr_i & (addr_i == A_IMR);
  wire w_icr  = wr_i & (addr_i == A_ICR);
  wire w_ila  = wr_i & (addr_i == A_ILA);
  wire w_ilb  = wr_i & (addr_i == A_ILB);
  wire w_mat  = wr_i & (addr_i == A_MAT);
  wire w_pra  = wr_i & (addr_i == A_PRA);
  wire w_prb  = wr_i & (addr_i == A_PRB);
  wire [31:0] cn32 = {cnb_ff, cna_ff};
  wire [31:0] il32 = {ilb_ff, ila_ff};
  // only the low mode field matters for the wide timer
  wire md_ok_a = (mda_ff == MD_ONE) | (mda_ff == MD_PER);
  wire md_ok_b = (mdb_ff == MD_ONE) | (mdb_ff == MD_PER);
  wire run_w   = wide & ena_ff & ~sta_ff & md_ok_a;
  wire zero_w  = run_w & (cn32 == 32'h0000_0000);
  // stall freezes the rtc unless stall permit is set
  wire rtc_stl  = (sta_ff | stb_ff) & ~permit_ff;
  wire rtc_step = rtc & ena_ff & tick & ~rtc_stl;
  wire rtc_hit  = rtc_step & (cn32 == mat_ff);
  wire rtc_new  = rtc & ~rtc_seen_ff;
  wire run_a    = split & ena_ff & ~sta_ff & md_ok_a;
  wire run_b    = split & enb_ff & ~stb_ff & md_ok_b;
  wire pz_a     = (psa_ff == 8'h00);
  wire pz_b     = (psb_ff == 8'h00);
  wire zero_a   = run_a & pz_a & (cna_ff == 16'h0000);
  wire zero_b   = run_b & pz_b & (cnb_ff == 16'h0000);
  wire to_a     = zero_w | zero_a;
  wire clr_ena  = to_a & (mda_ff == MD_ONE);
  wire clr_enb  = zero_b & (mdb_ff == MD_ONE);
  wire [2:0] set_ris = {zero_b, rtc_hit, to_a};
  wire [2:0] clr_ris = {wdata_i[I_BTO], wdata_i[I_RTC], wdata_i[I_ATO]} & {3{w_icr}};

  // one half step: prescaler runs first, counter moves when it wraps
  function automatic logic [23:0] half_step(
    input logic        run,
    input logic [15:0] cn,
    input logic [7:0]  ps,
    input logic [15:0] il,
    input logic [7:0]  pr
  );
    if (!run)
      half_step = {cn, ps};
    else if (ps != 8'h00)
      half_step = {cn, 8'(ps - 8'h01)};
    else if (cn == 16'h0000)
      half_step = {il, pr};
    else
      half_step = {16'(cn - 16'h0001), pr};
  endfunction : half_step

  // ==========================================
  // counter next state
  always_comb begin
    logic [31:0] n32;
    logic [23:0] ha, hb;
    n32 = cn32;
    ha  = half_step(run_a, cna_ff, psa_ff, ila_ff, pra_ff);
    hb  = half_step(run_b, cnb_ff, psb_ff, ilb_ff, prb_ff);
    nxt_psa = psa_ff;
    nxt_psb = psb_ff;
    if (wide && run_w)
      n32 = zero_w ? il32 : 32'(cn32 - 32'h1);
    else if (rtc && rtc_new)
      n32 = RTC_FIRST;
    else if (rtc && rtc_step)
      n32 = rtc_hit ? 32'h0000_0000 : 32'(cn32 + 32'h1);
    else if (split) begin
      n32     = {hb[23:8], ha[23:8]};
      nxt_psa = ha[7:0];
      nxt_psb = hb[7:0];
    end
    // a new load value is taken at once, running or not, except in rtc mode
    if (w_ila && !split && !rtc)
      n32 = wdata_i;
    if (w_ila && split)
      n32[15:0] = wdata_i[15:0];
    if (w_ilb && split)
      n32[31:16] = wdata_i[15:0];
    nxt_cna = n32[15:0];
    nxt_cnb = n32[31:16];
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_ff <= CFG_WIDE;
      mda_ff <= 2'h0;
      mdb_ff <= 2'h0;
      imr_ff <= 3'h0;
      mat_ff <= 32'h0000_0000;
    end else begin
      if (w_cfg) cfg_ff <= wdata_i[2:0];
      if (w_mda) mda_ff <= wdata_i[1:0];
      if (w_mdb) mdb_ff <= wdata_i[1:0];
      if (w_imr) imr_ff <= {wdata_i[I_BTO], wdata_i[I_RTC], wdata_i[I_ATO]};
      if (w_mat) mat_ff <= wdata_i;
    end
  end

  // control bits: a software write beats the one-shot self clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {ena_ff, sta_ff, ota_ff, permit_ff} <= 4'h0;
      {enb_ff, stb_ff, otb_ff}           <= 3'h0;
    end else if (w_ctl) begin
      ena_ff   <= wdata_i[C_ENA];
      sta_ff   <= wdata_i[C_STA];
      ota_ff   <= wdata_i[C_OTA];
      permit_ff <= wdata_i[C_PERMIT];
      enb_ff   <= wdata_i[C_ENB];
      stb_ff   <= wdata_i[C_STB];
      otb_ff   <= wdata_i[C_OTB];
    end else begin
      if (clr_ena) ena_ff <= 1'b0;
      if (clr_enb) enb_ff <= 1'b0;
    end
  end

  // load and prescale registers; wide write lands in both halves
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ila_ff <= CNT_RST;
      ilb_ff <= CNT_RST;
      pra_ff <= PRE_RST;
      prb_ff <= PRE_RST;
    end else begin
      if (w_ila) ila_ff <= wdata_i[15:0];
      if (w_ila && !split) ilb_ff <= wdata_i[31:16];
      else if (w_ilb) ilb_ff <= wdata_i[15:0];
      if (w_pra) pra_ff <= wdata_i[7:0];
      if (w_prb) prb_ff <= wdata_i[7:0];
    end
  end

  // ==========================================
  // counters and prescalers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cna_ff      <= CNT_RST;
      cnb_ff      <= CNT_RST;
      psa_ff      <= PRE_RST;
      psb_ff      <= PRE_RST;
      rtc_seen_ff <= 1'b0;
    end else begin
      cna_ff      <= nxt_cna;
      cnb_ff      <= nxt_cnb;
      psa_ff      <= nxt_psa;
      psb_ff      <= nxt_psb;
      rtc_seen_ff <= rtc_seen_ff | rtc;  // first rtc entry only
    end
  end

  // ==========================================
  // status, interrupt and trigger; set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ris_ff      <= 3'h0;
      irq_o       <= 1'b0;
      trig_low_o  <= 1'b0;
      trig_high_o <= 1'b0;
    end else begin
      ris_ff      <= (ris_ff & ~clr_ris) | set_ris;
      irq_o       <= |(ris_ff & imr_ff);
      trig_low_o  <= to_a & ota_ff;
      trig_high_o <= zero_b & otb_ff;
    end
  end

  // ==========================================
  // read path
  wire [31:0] ctl_rd = 32'({otb_ff, 3'h0, stb_ff, enb_ff, 2'h0,
                            ota_ff, permit_ff, 2'h0, sta_ff, ena_ff});
  wire [31:0] ris_rd = 32'({ris_ff[2], 4'h0, ris_ff[1], 2'h0, ris_ff[0]});
  wire [31:0] imr_rd = 32'({imr_ff[2], 4'h0, imr_ff[1], 2'h0, imr_ff[0]});
  wire [31:0] mis_rd = ris_rd & imr_rd;
  wire [31:0] cna_rd = split ? {16'h0000, cna_ff} : cn32;
  wire [31:0] ila_rd = split ? {16'h0000, ila_ff} : il32;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      A_CFG:   rd_mux = {29'h0, cfg_ff};
      A_MDA:   rd_mux = {30'h0, mda_ff};
      A_MDB:   rd_mux = {30'h0, mdb_ff};
      A_CTL:   rd_mux = ctl_rd;
      A_IMR:   rd_mux = imr_rd;
      A_RIS:   rd_mux = ris_rd;
      A_MIS:   rd_mux = mis_rd;
      A_ILA:   rd_mux = ila_rd;
      A_ILB:   rd_mux = {16'h0000, ilb_ff};
      A_MAT:   rd_mux = mat_ff;
      A_PRA:   rd_mux = {24'h0, pra_ff};
      A_PRB:   rd_mux = {24'h0, prb_ff};
      A_CNA:   rd_mux = cna_rd;
      A_CNB:   rd_mux = {16'h0000, cnb_ff};
      default: rd_mux = 32'h0000_0000;  // unmapped and clear reads zero
    endcase
  end

  // data only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) rdata_o <= 32'h0000_0000;
    else          rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
  end

  // ==========================================
  // checks
  AST_RST_CNT: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> cna_ff == 16'hffff && cnb_ff == 16'hffff && ila_ff == 16'hffff
      && !ena_ff)
    else $error("counters not ffff after reset");
  AST_RST_PRE: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> psa_ff == 8'h00 && prb_ff == 8'h00)
    else $error("prescale not zero after reset");
  AST_RELOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    zero_w && !wr_i |=> cn32 == $past(il32))
    else $error("wide reload missed");
  AST_ONESHOT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    zero_w && mda_ff == 2'h1 && !w_ctl |=> !ena_ff)
    else $error("one-shot did not stop");
  AST_TO_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    to_a |=> ris_ff[0] ##1 (ris_ff[0] || $past(w_icr)))
    else $error("timeout flag lost");
  AST_TRIG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    trig_low_o |-> $past(ota_ff) && $past(cna_ff) == 16'h0000)
    else $error("trigger without zero");
  AST_STALL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wide && sta_ff && !wr_i |=> $stable(cn32))
    else $error("stalled counter moved");
  AST_ROLL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rtc_hit && !wr_i |=> cn32 == 32'h0000_0000)
    else $error("rtc did not roll over");
  AST_PRESCALE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    run_a && !pz_a && !wr_i |=> $stable(cna_ff) && psa_ff == $past(psa_ff) - 8'h01)
    else $error("prescaler step wrong");
  AST_READ32: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == A_CNA && !split |=> rdata_o == $past(cn32))
    else $error("wide count read wrong");
  AST_LOAD_NOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    w_ila && wide |=> cn32 == $past(wdata_i))
    else $error("wide load not taken next cycle");
  // split halves, rtc and interrupt line
  AST_HALF_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    zero_b |=> ris_ff[2])
    else $error("high half timeout flag missed");
  AST_HALF_RELOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    zero_b && !wr_i |=> cnb_ff == $past(ilb_ff) && psb_ff == $past(prb_ff))
    else $error("high half reload missed");
  AST_STALL_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    split && sta_ff && !wr_i |=> $stable(cna_ff) && $stable(psa_ff))
    else $error("stalled low half moved");
  AST_STALL_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    split && stb_ff && !wr_i |=> $stable(cnb_ff) && $stable(psb_ff))
    else $error("stalled high half moved");
  AST_RTC_FIRST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rtc_new |=> cn32 == RTC_FIRST)
    else $error("rtc first load not one");
  AST_RTC_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rtc_hit |=> ris_ff[1])
    else $error("rtc match flag missed");
  AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    |(ris_ff & imr_ff) |=> irq_o)
    else $error("interrupt line not raised");
endmodule : dhtrc_core

// ---- include/dhtrc_pkg.sv ----
// Purpose: constants and types of the dual half timer
// Assumes: 32-bit register port, byte addresses
// Notes:   offsets are word aligned
package dhtrc_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_MDA  = 8'h04;
  localparam logic [7:0] A_MDB  = 8'h08;
  localparam logic [7:0] A_CTL  = 8'h0c;
  localparam logic [7:0] A_IMR  = 8'h18;
  localparam logic [7:0] A_RIS  = 8'h1c;
  localparam logic [7:0] A_MIS  = 8'h20;
  localparam logic [7:0] A_ICR  = 8'h24;
  localparam logic [7:0] A_ILA  = 8'h28;
  localparam logic [7:0] A_ILB  = 8'h2c;
  localparam logic [7:0] A_MAT  = 8'h30;
  localparam logic [7:0] A_PRA  = 8'h38;
  localparam logic [7:0] A_PRB  = 8'h3c;
  localparam logic [7:0] A_CNA  = 8'h48;
  localparam logic [7:0] A_CNB  = 8'h4c;
  // ==========================================
  // field values and positions
  localparam logic [2:0] CFG_WIDE  = 3'h0;
  localparam logic [2:0] CFG_RTC   = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] MD_ONE    = 2'h1;
  localparam logic [1:0] MD_PER    = 2'h2;
  localparam int C_ENA = 0, C_STA = 1, C_PERMIT = 4, C_OTA = 5;
  localparam int C_ENB = 8, C_STB = 9, C_OTB = 13;
  localparam int I_ATO = 0, I_RTC = 3, I_BTO = 8;
  // ==========================================
  // reset values and timing
  localparam logic [15:0] CNT_RST   = 16'hffff;
  localparam logic [7:0]  PRE_RST   = 8'h00;
  localparam logic [31:0] RTC_FIRST = 32'h00000001;
  localparam int RTC_IN_HZ  = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam int RTC_DIV    = RTC_IN_HZ / RTC_OUT_HZ;
  // ==========================================
  // global mode, one-hot
  typedef enum logic [2:0] {
    GM_WIDE = 3'b001, GM_RTC = 3'b010, GM_SPLIT = 3'b100
  } dhtrc_gm_t;
  function automatic dhtrc_gm_t dhtrc_gm(input logic [2:0] c);
    unique case (c)
      CFG_RTC:   dhtrc_gm = GM_RTC;
      CFG_SPLIT: dhtrc_gm = GM_SPLIT;
      default:   dhtrc_gm = GM_WIDE; // unused codes act as wide timer
    endcase
  endfunction : dhtrc_gm
endpackage : dhtrc_pkg

// ---- logic/dhtrc_rtc_div.sv ----
// Purpose: sync the 32.768 kHz pin and divide it to a 1 Hz tick
// Assumes: pin far slower than sys_clk_i
// Notes:   tick is one sys_clk_i cycle per DIV rising pin edges
`timescale 1ns/1ps
module dhtrc_rtc_div #(
  parameter int DIV = 32768
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // pin and tick
  input  wire logic pin_i,
  output logic      tick_o
);
  logic        s1_ff, s2_ff, s3_ff;
  logic [15:0] cnt_ff;
  wire         rise = s2_ff & ~s3_ff; // first stage is never looked at
  wire         last = (cnt_ff == 16'(DIV - 1));
  // ==========================================
  // synchroniser and divider
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {s1_ff, s2_ff, s3_ff} <= 3'h0;
      cnt_ff                <= 16'h0000;
      tick_o                <= 1'b0;
    end else begin
      s1_ff  <= pin_i;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      cnt_ff <= rise ? (last ? 16'h0000 : cnt_ff + 16'h0001) : cnt_ff;
      tick_o <= rise & last;
    end
  end
endmodule : dhtrc_rtc_div

// ---- tb/dhtrc_tb.sv ----
// Purpose: self-checking bench for the dual half timer core
// Assumes: rtc divider shortened to 4 pin edges, pin free-running
// Notes:   expectations follow the contract walks, not the design outputs
`timescale 1ns/1ps
module testbench;
  import dhtrc_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        pin       = 1'b0;
  logic [31:0] rdata_o;
  logic        trig_low_o, trig_high_o, irq_o;
  int          err_count = 0;
  int          checked   = 0;

  dhtrc_core #(.RTC_EDGES(4)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_pin_zero_i(pin),
    .trig_low_o(trig_low_o), .trig_high_o(trig_high_o), .irq_o(irq_o));

  // 40 MHz system clock; pin toggles every 8 edges, 400 ns period, far slower
  always #12.5 sys_clk_i = ~sys_clk_i;
  always begin
    repeat (8) @(posedge sys_clk_i);
    pin <= ~pin;
  end

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic clks(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : clks

  // counts cycles up to the next trigger pulse, bounded
  task automatic wait_trig(input bit hi, output int n);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while ((hi ? trig_high_o : trig_low_o) !== 1'b1 && n < 600);
  endtask : wait_trig

  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [7:0]  ad [10] = '{A_CNA, A_CNB, A_PRA, A_PRB, A_CTL, A_CFG, A_RIS, A_MAT, 8'hfc,
                             A_ILA};
    logic [31:0] ex [10] = '{32'hffffffff, 32'hffff, 0, 0, 0, 0, 0, 0, 0, 32'hffffffff};
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      rd(ad[i], d);
      chk(d, ex[i]);
    end
    chk({trig_low_o, trig_high_o, irq_o}, 0);
  endtask : t_reset

  task automatic t_wide_periodic;
    logic [31:0] d, e;
    int n;
    wr(A_CFG, CFG_WIDE);
    wr(A_MDA, MD_PER); // high mode left at reset value on purpose
    wr(A_ILA, 32'h00010002);
    rd(A_CNA, d);
    chk(d, 32'h00010002);
    rd(A_CNB, d);
    chk(d, 32'h1);
    wr(A_ILA, 32'h2);
    wr(A_IMR, 32'h1);
    wr(A_CTL, 32'h21);
    wait_trig(0, n);
    wait_trig(0, n);
    chk(n, 3);
    rd(A_RIS, d);
    chk(d & 32'h1, 32'h1);
    rd(A_MIS, d);
    chk(d & 32'h1, 32'h1);
    chk(irq_o, 1'b1);
    rd(A_CTL, d);
    chk(d & 32'h1, 32'h1);
    // stall freezes the wide count
    wr(A_ILA, 32'h100);
    wr(A_CTL, 32'h23);
    rd(A_CNA, d);
    clks(5);
    rd(A_CNA, e);
    chk(e, d);
    wr(A_CTL, 32'h21);
    wr(A_ILA, 32'h50);
    rd(A_CNA, d);
    chk(d, 32'h4f);
    wr(A_CTL, 32'h0);
    wr(A_ICR, 32'h1);
    rd(A_RIS, d);
    chk(d, 32'h0);
    clks(2);
    chk(irq_o, 1'b0);
  endtask : t_wide_periodic

  task automatic t_wide_oneshot;
    logic [31:0] d;
    int n;
    wr(A_MDA, MD_ONE);
    wr(A_ILA, 32'h3);
    wr(A_CTL, 32'h21);
    wait_trig(0, n);
    chk(n, 4);
    chk(trig_low_o, 1'b1);
    clks(3);
    rd(A_CTL, d);
    chk(d & 32'h1, 32'h0);
    rd(A_CNA, d);
    chk(d, 32'h3);
    wr(A_ICR, 32'h1);
  endtask : t_wide_oneshot

  // split high half, prescale table including the all-ones boundary
  task automatic t_split;
    logic [7:0]  ps [3] = '{8'h00, 8'h02, 8'hff};
    logic [31:0] d;
    int n;
    wr(A_CFG, CFG_SPLIT);
    wr(A_MDB, MD_PER);
    wr(A_IMR, 32'h100);
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, 32'h0);
      wr(A_PRB, {24'h0, ps[i]});
      wr(A_ILB, 32'h1);
      wr(A_CTL, 32'h2100);
      wait_trig(1, n);
      wait_trig(1, n);
      chk(n, 2 * (ps[i] + 1));
    end
    wr(A_CTL, 32'h0);
    rd(A_RIS, d);
    chk(d & 32'h101, 32'h100);
    chk(irq_o, 1'b1);
    wr(A_ICR, 32'h100);
    wr(A_MDB, MD_ONE);
    wr(A_CTL, 32'h2300);
    clks(20);
    chk(trig_high_o, 1'b0);
    wr(A_CTL, 32'h0);
    // low half loaded and enabled while stalled must not move until released
    wr(A_MDA, MD_PER);
    wr(A_ILA, 32'h40);
    wr(A_CTL, 32'h3);
    clks(20);
    rd(A_CNA, d);
    chk(d, 32'h40);
    wr(A_CTL, 32'h1);
    rd(A_CNA, d);
    chk(d, 32'h3f);
    wr(A_CTL, 32'h0);
  endtask : t_split

  task automatic t_rtc;
    logic [31:0] d, e;
    int n;
    wr(A_CFG, CFG_RTC);
    rd(A_CNA, d);
    chk(d, 32'h1);
    wr(A_MAT, 32'h3);
    wr(A_IMR, 32'h8);
    wr(A_CTL, 32'h1);
    n = 0;
    do begin
      rd(A_RIS, d);
      n++;
    end while (d[I_RTC] !== 1'b1 && n < 400);
    rd(A_CNA, e);
    chk(e, 32'h0);
    rd(A_MIS, d);
    chk(d & 32'h8, 32'h8);
    chk(irq_o, 1'b1);
    wr(A_ICR, 32'h8);
    rd(A_RIS, d);
    chk(d, 32'h0);
    wr(A_CTL, 32'h3);
    rd(A_CNA, d);
    clks(150);
    rd(A_CNA, e);
    chk(e, d);
    wr(A_CTL, 32'h13);
    rd(A_CNA, d);
    clks(150);
    rd(A_CNA, e);
    chk(e !== d, 1);
  endtask : t_rtc

  // ==========================================
  // verdict, main sequence and watchdog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clks(12);
    rst_n_i <= 1'b1;
    t_reset();
    t_wide_periodic();
    t_wide_oneshot();
    t_split();
    t_rtc();
    report_and_stop();
  end

  // whole run needs a few thousand cycles; 40000 leaves wide margin
  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end
endmodule : testbench
